// ### verilog/rx_port_eq_and_tag_regs.sv
// receive-port equalizer control, crc flag gating and embedded-line tagging
`timescale 1ns/1ps
`default_nettype none

module rx_port_eq_and_tag_regs
   import eq_tag_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int TIMER_W = 16,
   parameter int EQ_W = 4,
   parameter logic [7:0] CAP_RESET = 8'h00
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output var logic [7:0] reg_rdata,
   input wire logic read_port,
   input wire logic [NUM_PORTS-1:0] write_port_en,
   input wire logic [TIMER_W-1:0] eq_relock_period,
   input wire logic [3:0] sample_filter_floor,
   input wire logic [3:0] sample_filter_ceiling,
   input wire logic [EMBED_CODE_W-1:0] ten_bit_raw_type_code,
   input wire logic [EMBED_CODE_W-1:0] twelve_bit_raw_type_code,
   input wire link_in_t [NUM_PORTS-1:0] link_in,
   input wire pkt_in_t [NUM_PORTS-1:0] pkt_in,
   output var logic [NUM_PORTS-1:0][EQ_W-1:0] eq_setting,
   output var logic [NUM_PORTS-1:0][3:0] filter_setting,
   output var logic [NUM_PORTS-1:0] eq_locked,
   output var logic [NUM_PORTS-1:0] crc_err_flag,
   output var pkt_out_t [NUM_PORTS-1:0] pkt_out
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   if (NUM_PORTS < 1 || NUM_PORTS > 2)
   begin : g_bad_ports
      $error("port count must be 1 or 2");
   end
   if (TIMER_W < 2 || EQ_W < 1)
   begin : g_bad_width
      $error("timer or equalizer width too small");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      eq_state_t st;
      logic [TIMER_W-1:0] tmr;
      logic [8:0] errs;
      logic [EQ_W-1:0] eq;
      logic [3:0] sf;
      logic locked;
      logic crc_flag;
      logic [1:0] lines;
      pkt_out_t pkt;
      logic [7:0] cap;
      logic [7:0] embed;
   } port_t;

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] limit;
      logic [7:0] rdata;
      port_t [NUM_PORTS-1:0] port;
   } state_t;

   state_t s_q;
   state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // next candidate of the equalizer / filter search
   function automatic logic [EQ_W+3:0] next_setting(
      input logic [EQ_W-1:0] eq,
      input logic [3:0] sf,
      input logic sf_en,
      input logic order,
      input logic [3:0] lo,
      input logic [3:0] hi
   );
      logic [EQ_W-1:0] eq_n;
      logic [3:0] sf_n;
      eq_n = eq;
      sf_n = sf;
      if (!sf_en) // R09
      begin
         eq_n = eq + EQ_W'(1);
         sf_n = lo;
      end
      else if (!order) // R08
      begin
         eq_n = eq + EQ_W'(1);
         if (eq == '1)
         begin
            sf_n = (sf >= hi) ? lo : sf + 4'h1;
         end
      end
      else
      begin
         if (sf >= hi) // R08
         begin
            sf_n = lo;
            eq_n = eq + EQ_W'(1);
         end
         else
         begin
            sf_n = sf + 4'h1;
         end
      end
      return {eq_n, sf_n};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   logic [2:0] err_sel;
   logic two_phase;
   logic loop_order;
   logic sf_en;
   logic [TIMER_W-1:0] full_cnt;
   logic [TIMER_W-1:0] half_cnt;
   logic [3:0] sf_lo;
   logic [3:0] sf_hi;

   always_comb
   begin
      err_sel = s_q.ctl[CTL_ERR_SEL_LSB +: 3];
      two_phase = s_q.ctl[CTL_TWO_PHASE_BIT];
      loop_order = s_q.ctl[CTL_LOOP_ORDER_BIT];
      sf_en = s_q.ctl[CTL_SF_EN_BIT];
      full_cnt = (eq_relock_period == '0) ? TIMER_W'(1) : eq_relock_period;
      half_cnt = eq_relock_period >> 1; // R02
      if (half_cnt == '0)
      begin
         half_cnt = TIMER_W'(1);
      end
      sf_lo = (sample_filter_floor > SF_LIMIT) ? SF_LIMIT : sample_filter_floor; // R19
      sf_hi = (sample_filter_ceiling > SF_LIMIT) ? SF_LIMIT : sample_filter_ceiling; // R19
      if (sf_hi < sf_lo)
      begin
         sf_hi = sf_lo; // R19
      end
   end

   always_comb
   begin
      logic err_hit;
      logic step;
      logic [EQ_W+3:0] nxt;
      logic [1:0] lines_now;
      logic embed_now;
      logic [TIMER_W-1:0] tmr_inc;
      s_d = s_q;
      err_hit = 1'b0;
      step = 1'b0;
      nxt = '0;
      lines_now = '0;
      embed_now = 1'b0;
      tmr_inc = '0;

      // register writes
      if (reg_wr)
      begin
         if (reg_addr == ADDR_EQ_CTL)
         begin
            s_d.ctl = reg_wdata & CTL_WRITE_MASK;
         end
         if (reg_addr == ADDR_EQ_LIMIT)
         begin
            s_d.limit = reg_wdata; // R10
         end
      end

      // register reads, one cycle latency
      if (reg_rd)
      begin
         if (reg_addr == ADDR_EQ_CTL)
         begin
            s_d.rdata = s_q.ctl;
         end
         else if (reg_addr == ADDR_EQ_LIMIT)
         begin
            s_d.rdata = s_q.limit;
         end
         else if (reg_addr == ADDR_CAP && int'(read_port) < NUM_PORTS)
         begin
            s_d.rdata = s_q.port[read_port].cap; // R12
         end
         else if (reg_addr == ADDR_EMBED && int'(read_port) < NUM_PORTS)
         begin
            s_d.rdata = s_q.port[read_port].embed; // R12
         end
         else
         begin
            s_d.rdata = READ_ZERO; // R11
         end
      end

      for (int p = 0; p < NUM_PORTS; p++)
      begin
         // banked writes
         if (reg_wr && write_port_en[p])
         begin
            if (reg_addr == ADDR_CAP)
            begin
               s_d.port[p].cap = reg_wdata; // R12
            end
            if (reg_addr == ADDR_EMBED)
            begin
               s_d.port[p].embed = reg_wdata; // R12
            end
         end

         s_d.port[p].crc_flag = link_in[p].enc_crc_err & s_q.port[p].cap[CAP_CRC_FLAG_BIT]; // R13

         // adaptive equalizer
         err_hit = (err_sel[ERR_CLK_BIT] & link_in[p].clk_err) // R04
                 | (err_sel[ERR_ENC_BIT] & link_in[p].enc_err) // R04
                 | (err_sel[ERR_PAR_BIT] & link_in[p].par_err); // R01
         tmr_inc = s_q.port[p].tmr + TIMER_W'(1);
         step = 1'b0;
         unique case (s_q.port[p].st)
            EQ_WAIT:
            begin
               s_d.port[p].tmr = tmr_inc;
               if (two_phase && tmr_inc >= half_cnt) // R07
               begin
                  s_d.port[p].st = EQ_WATCH;
                  s_d.port[p].tmr = '0;
                  s_d.port[p].errs = '0;
               end
               else if (!two_phase && tmr_inc >= full_cnt) // R06
               begin
                  if (link_in[p].lock)
                  begin
                     s_d.port[p].st = EQ_LOCKED;
                     s_d.port[p].tmr = '0;
                     s_d.port[p].errs = '0;
                  end
                  else
                  begin
                     step = 1'b1;
                  end
               end
            end
            EQ_WATCH:
            begin
               s_d.port[p].tmr = tmr_inc;
               if (err_hit) // R05 R07
               begin
                  step = 1'b1;
               end
               else if (tmr_inc >= half_cnt)
               begin
                  if (link_in[p].lock)
                  begin
                     s_d.port[p].st = EQ_LOCKED;
                     s_d.port[p].tmr = '0;
                     s_d.port[p].errs = '0;
                  end
                  else
                  begin
                     step = 1'b1;
                  end
               end
            end
            EQ_LOCKED:
            begin
               s_d.port[p].tmr = tmr_inc;
               if (err_hit && s_q.port[p].errs != '1)
               begin
                  s_d.port[p].errs = s_q.port[p].errs + 9'h001; // R01
               end
               if (!link_in[p].lock)
               begin
                  step = 1'b1;
               end
               else if (tmr_inc >= half_cnt) // R02
               begin
                  if (s_d.port[p].errs > {1'b0, s_q.limit}) // R03
                  begin
                     step = 1'b1;
                  end
                  else
                  begin
                     s_d.port[p].tmr = '0;
                     s_d.port[p].errs = '0;
                  end
               end
            end
         endcase

         if (step)
         begin
            nxt = next_setting(s_q.port[p].eq, s_q.port[p].sf, sf_en, loop_order, sf_lo, sf_hi);
            s_d.port[p].eq = nxt[EQ_W+3:4];
            s_d.port[p].sf = nxt[3:0];
            s_d.port[p].st = EQ_WAIT;
            s_d.port[p].tmr = '0;
            s_d.port[p].errs = '0; // R20
         end
         else if (s_q.port[p].sf < sf_lo || s_q.port[p].sf > sf_hi)
         begin
            s_d.port[p].sf = sf_lo; // R19
         end
         s_d.port[p].locked = (s_d.port[p].st == EQ_LOCKED);

         // embedded-line tagging
         lines_now = pkt_in[p].frame_start ? 2'b00 : s_q.port[p].lines;
         s_d.port[p].lines = lines_now;
         s_d.port[p].pkt.valid = pkt_in[p].long_pkt;
         s_d.port[p].pkt.embedded = 1'b0;
         if (pkt_in[p].long_pkt)
         begin
            embed_now = pkt_in[p].raw_mode // R18
                      && lines_now < s_q.port[p].embed[EMBED_CNT_LSB +: 2]; // R15 R16
            s_d.port[p].pkt.embedded = embed_now;
            if (embed_now)
            begin
               s_d.port[p].pkt.dtype = s_q.port[p].embed[EMBED_CODE_W-1:0]; // R17
            end
            else if (pkt_in[p].raw_mode)
            begin
               s_d.port[p].pkt.dtype = pkt_in[p].raw12 ? twelve_bit_raw_type_code
                                                        : ten_bit_raw_type_code; // R15
            end
            else
            begin
               s_d.port[p].pkt.dtype = pkt_in[p].dtype; // R18
            end
            if (lines_now != 2'b11)
            begin
               s_d.port[p].lines = lines_now + 2'b01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.ctl <= CTL_RESET; // R01 R09
         s_q.limit <= LIMIT_RESET; // R10
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            s_q.port[p].cap <= CAP_RESET;
            s_q.port[p].embed <= EMBED_RESET; // R17
            s_q.port[p].st <= EQ_WAIT;
         end
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb
   begin
      reg_rdata = s_q.rdata;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         eq_setting[p] = s_q.port[p].eq;
         filter_setting[p] = s_q.port[p].sf;
         eq_locked[p] = s_q.port[p].locked;
         crc_err_flag[p] = s_q.port[p].crc_flag;
         pkt_out[p] = s_q.port[p].pkt;
      end
   end

endmodule

`default_nettype wire

// ### verilog/eq_tag_pkg.sv
// constants and carriers for the receive-port equalizer and tagging registers
//
// Overview of operation
// R01: any error-select bit set enables link error counting during adaption; resets to 0x7.
// R02: errors accumulate over half of the external relock period.
// R03: count strictly above the error limit steps the equalizer to the next setting.
// R04: select bit 6 clock errors, bit 5 encoding errors, bit 4 parity errors.
// R05: two-phase mode also uses selected errors to validate a candidate setting.
// R06: two-phase off: wait the full period, then judge by instantaneous lock.
// R07: two-phase on: wait half, watch errors over other half; error steps at once.
// R08: loop order 0 makes equalizer inner loop, 1 makes sampling filter inner loop.
// R09: sampling filter adaption runs while its enable bit is set; resets to one.
// R10: host must not program the error limit to zero; it resets to one.
// R11: addresses 0x44 to 0x49 are read-only and return zero.
// R12: capability and embedded-type registers are banked per port via the port select.
// R13: capability bit 4 passes encoder crc errors when one, suppresses them when zero.
// R14: host should set the crc flag enable and clear the encoder crc disable.
// R15: raw mode with line count 00 forwards every long packet as raw video.
// R16: line count 1 to 3 tags that many leading long packets per frame as embedded.
// R17: embedded lines carry the six-bit embedded type code, reset 0x12.
// R18: embedded tagging has no effect when the port takes csi formatted input.
// R19: sampling filter stays within floor and ceiling, both 0 to 14, ceiling at least floor.
// R20: error accumulation restarts for every new candidate equalizer setting.
package eq_tag_pkg;

   localparam logic [7:0] ADDR_EQ_CTL = 8'h42;
   localparam logic [7:0] ADDR_EQ_LIMIT = 8'h43;
   localparam logic [7:0] ADDR_RSVD_FIRST = 8'h44;
   localparam logic [7:0] ADDR_RSVD_LAST = 8'h49;
   localparam logic [7:0] ADDR_CAP = 8'h4A;
   localparam logic [7:0] ADDR_EMBED = 8'h4B;

   localparam int CTL_ERR_SEL_LSB = 4;
   localparam int CTL_TWO_PHASE_BIT = 2;
   localparam int CTL_LOOP_ORDER_BIT = 1;
   localparam int CTL_SF_EN_BIT = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;
   localparam logic [7:0] CTL_RESET = 8'h71;
   localparam logic [7:0] LIMIT_RESET = 8'h01;
   localparam logic [7:0] EMBED_RESET = 8'h12;
   localparam logic [7:0] READ_ZERO = 8'h00;

   localparam int ERR_CLK_BIT = 2;
   localparam int ERR_ENC_BIT = 1;
   localparam int ERR_PAR_BIT = 0;

   localparam int CAP_CRC_FLAG_BIT = 4;
   localparam int EMBED_CNT_LSB = 6;
   localparam int EMBED_CODE_W = 6;

   localparam logic [3:0] SF_LIMIT = 4'hE;

   typedef enum logic [1:0] {EQ_WAIT, EQ_WATCH, EQ_LOCKED} eq_state_t;

   typedef struct packed {
      logic lock;
      logic clk_err;
      logic enc_err;
      logic par_err;
      logic enc_crc_err;
   } link_in_t;

   typedef struct packed {
      logic frame_start;
      logic long_pkt;
      logic raw_mode;
      logic raw12;
      logic [EMBED_CODE_W-1:0] dtype;
   } pkt_in_t;

   typedef struct packed {
      logic valid;
      logic embedded;
      logic [EMBED_CODE_W-1:0] dtype;
   } pkt_out_t;

endpackage

// ### test/rx_port_eq_and_tag_regs_sva.sv
// assertion checker for the receive-port equalizer and tagging registers
`timescale 1ns/1ps
`default_nettype none
module rx_port_eq_and_tag_regs_sva
   import eq_tag_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int TIMER_W = 16,
   parameter int EQ_W = 4
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [TIMER_W-1:0] eq_relock_period,
   input wire logic [EMBED_CODE_W-1:0] twelve_bit_raw_type_code,
   input wire link_in_t [NUM_PORTS-1:0] link_in,
   input wire pkt_in_t [NUM_PORTS-1:0] pkt_in,
   input wire logic [NUM_PORTS-1:0][EQ_W-1:0] eq_setting,
   input wire logic [NUM_PORTS-1:0][3:0] filter_setting,
   input wire logic [NUM_PORTS-1:0] eq_locked,
   input wire logic [NUM_PORTS-1:0] crc_err_flag,
   input wire pkt_out_t [NUM_PORTS-1:0] pkt_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
   // cycles since the last equalizer setting change while the link is unlocked
   logic [EQ_W-1:0] eq_q;
   int stay_q;
   always_ff @(posedge clk)
   begin
      eq_q <= eq_setting[0];
      if (sys_rst || eq_setting[0] != eq_q || link_in[0].lock)
         stay_q <= 0;
      else
         stay_q <= stay_q + 1;
   end
////////////////////////////////////////////////////////////////////////////////
   a_rsvd_read_zero: assert property (
      reg_rd && reg_addr >= ADDR_RSVD_FIRST && reg_addr <= ADDR_RSVD_LAST
      |=> reg_rdata == READ_ZERO)
      else $error("reserved read not zero");
   a_crc_flag_cause: assert property (
      crc_err_flag[0] |-> $past(link_in[0].enc_crc_err))
      else $error("crc flag without encoder error");
   a_pkt_valid_next: assert property (
      pkt_in[0].long_pkt |=> pkt_out[0].valid)
      else $error("long packet not forwarded");
   a_valid_has_cause: assert property (
      pkt_out[0].valid |-> $past(pkt_in[0].long_pkt))
      else $error("packet out without packet in");
   a_embed_raw_only: assert property (
      pkt_out[0].embedded |-> pkt_out[0].valid && $past(pkt_in[0].raw_mode))
      else $error("embedded tag outside raw mode");
   a_raw12_code: assert property (
      pkt_out[0].valid && !pkt_out[0].embedded && $past(pkt_in[0].raw_mode && pkt_in[0].raw12)
      |-> pkt_out[0].dtype == $past(twelve_bit_raw_type_code))
      else $error("wrong twelve-bit type code");
   a_csi_code_kept: assert property (
      pkt_out[0].valid && !$past(pkt_in[0].raw_mode)
      |-> pkt_out[0].dtype == $past(pkt_in[0].dtype))
      else $error("csi type code altered");
   a_filter_in_range: assert property (
      filter_setting[0] <= SF_LIMIT)
      else $error("sampling filter out of range");
   a_lock_needs_link: assert property (
      $rose(eq_locked[0]) |-> $past(link_in[0].lock) || $past(link_in[0].lock, 2))
      else $error("locked without link lock");
   a_step_bounded: assert property (
      stay_q <= 2 * eq_relock_period + 4)
      else $error("equalizer stuck while unlocked");
endmodule

bind rx_port_eq_and_tag_regs rx_port_eq_and_tag_regs_sva #(
   .NUM_PORTS(NUM_PORTS), .TIMER_W(TIMER_W), .EQ_W(EQ_W)
) i_sva (
   .clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .eq_relock_period,
   .twelve_bit_raw_type_code, .link_in, .pkt_in, .eq_setting, .filter_setting,
   .eq_locked, .crc_err_flag, .pkt_out
);
`default_nettype wire

// ### test/rx_port_eq_and_tag_regs_tb.sv
// self-checking bench for the receive-port equalizer and tagging registers
`timescale 1ns/1ps
`default_nettype none
module rx_port_eq_and_tag_regs_tb
   import eq_tag_pkg::*;
();
   logic clk;
   logic sys_rst;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic read_port;
   logic [1:0] write_port_en;
   logic [7:0] eq_relock_period;
   logic [3:0] sample_filter_floor;
   logic [3:0] sample_filter_ceiling;
   logic lock0;
   logic [2:0] errs;
   logic [1:0] crc_err;
   wire link_in_t [1:0] link_in;
   pkt_in_t [1:0] pkt_in;
   logic [1:0][3:0] eq_setting;
   logic [1:0][3:0] filter_setting;
   logic [1:0] eq_locked;
   logic [1:0] crc_err_flag;
   pkt_out_t [1:0] pkt_out;
   logic [3:0] eq_old;
   logic [7:0] adr;
   logic [2:0] sel;
   logic [1:0] n;
   logic [5:0] dt;
   logic emb;
   int num_errors;
   int check_count;
   int k;
   int i;

   assign link_in[0] = {lock0, errs, crc_err[0]};
   assign link_in[1] = {4'h0, crc_err[1]};

   rx_port_eq_and_tag_regs #(.NUM_PORTS(2), .TIMER_W(8), .EQ_W(4)) i_dut (
      .clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .read_port,
      .write_port_en, .eq_relock_period, .sample_filter_floor, .sample_filter_ceiling,
      .ten_bit_raw_type_code(6'h2B), .twelve_bit_raw_type_code(6'h2C), .link_in, .pkt_in,
      .eq_setting, .filter_setting, .eq_locked, .crc_err_flag, .pkt_out
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one register write or read-and-compare
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      if (!w)
         chk(reg_rdata, d);
      @(negedge clk);
   endtask

   // waits a bounded time for the port 0 equalizer to step
   task automatic settle(input int lim, input logic [7:0] exp_move);
      logic [7:0] moved;
      moved = 8'h00;
      eq_old = eq_setting[0];
      for (int j = 0; j < lim && moved == 8'h00; j++)
      begin
         @(negedge clk);
         if (eq_setting[0] !== eq_old)
            moved = 8'h01;
      end
      chk(moved, exp_move);
      if (moved == 8'h01)
         chk({4'h0, eq_setting[0]}, {4'h0, eq_old + 4'h1});
      else if (exp_move == 8'h01)
         tally_and_finish();
   endtask

   // waits a bounded time for port 0 to change equalizer or filter setting
   task automatic step_to(input logic [3:0] exp_eq, input logic [3:0] exp_sf);
      logic [7:0] was;
      was = {eq_setting[0], filter_setting[0]};
      for (int j = 0; j < 20 && {eq_setting[0], filter_setting[0]} === was; j++)
         @(negedge clk);
      chk({eq_setting[0], filter_setting[0]}, {exp_eq, exp_sf});
   endtask

   task automatic wait_lock();
      for (int j = 0; j < 60 && eq_locked[0] !== 1'b1; j++)
         @(negedge clk);
      chk({7'h00, eq_locked[0]}, 8'h01);
      if (eq_locked[0] !== 1'b1)
         tally_and_finish();
   endtask

   task automatic pkt(input logic fs, raw, r12, em, input logic [5:0] code);
      pkt_in[0] = {fs, 1'b1, raw, r12, 6'h1E};
      @(negedge clk);
      pkt_in[0] = '0;
      chk({6'h00, pkt_out[0].valid, pkt_out[0].embedded}, {7'h01, em});
      chk({2'h0, pkt_out[0].dtype}, {2'h0, code});
      @(negedge clk);
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      read_port = 1'b0;
      write_port_en = 2'b11;
      eq_relock_period = 8'h08;
      sample_filter_floor = 4'h3;
      sample_filter_ceiling = 4'h9;
      lock0 = 1'b1;
      errs = 3'b000;
      crc_err = 2'b00;
      pkt_in = '0;
      num_errors = 0;
      check_count = 0;
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      xfer(1'b0, ADDR_EQ_CTL, CTL_RESET);
      xfer(1'b0, ADDR_EQ_LIMIT, LIMIT_RESET);
      xfer(1'b0, ADDR_EMBED, EMBED_RESET);
      for (adr = ADDR_RSVD_FIRST; adr <= ADDR_RSVD_LAST; adr++)
      begin
         xfer(1'b1, adr, 8'hFF);
         xfer(1'b0, adr, READ_ZERO);
      end
      xfer(1'b0, 8'hE0, READ_ZERO);
      xfer(1'b1, ADDR_EQ_CTL, 8'hFF);
      xfer(1'b0, ADDR_EQ_CTL, CTL_WRITE_MASK);
      $display("register test done");
      for (k = 0; k < 2; k++)
      begin
         write_port_en = 2'(1 << k);
         xfer(1'b1, ADDR_EMBED, 8'h40 + 8'(k));
         xfer(1'b1, ADDR_CAP, k == 0 ? 8'h10 : 8'hEF);
      end
      for (k = 0; k < 2; k++)
      begin
         read_port = k[0];
         xfer(1'b0, ADDR_EMBED, 8'h40 + 8'(k));
         xfer(1'b0, ADDR_CAP, k == 0 ? 8'h10 : 8'hEF);
      end
      crc_err = 2'b11;
      @(negedge clk);
      crc_err = 2'b00;
      chk({6'h00, crc_err_flag}, 8'h01);
      $display("bank and crc test done");
      write_port_en = 2'b01;
      for (k = 0; k < 5; k++)
      begin
         n = (k == 4) ? 2'b11 : 2'(k);
         xfer(1'b1, ADDR_EMBED, {n, 6'h12});
         for (i = 0; i < 4; i++)
         begin
            emb = (k < 4) && (i < n);
            dt = k == 4 ? 6'h1E : k[0] ? 6'h2C : 6'h2B;
            pkt(i == 0, k < 4, k[0], emb, emb ? 6'h12 : dt);
         end
      end
      $display("packet test done");
      wait_lock();
      for (k = 0; k < 4; k++)
      begin
         sel = 3'(1 << k);
         xfer(1'b1, ADDR_EQ_CTL, {1'b0, sel, 4'h0});
         xfer(1'b1, ADDR_EQ_LIMIT, 8'h04);
         errs = ~sel;
         settle(40, 8'h00);
         if (sel != 3'b000)
         begin
            errs = sel;
            settle(40, 8'h00);
            xfer(1'b1, ADDR_EQ_LIMIT, 8'h03);
            settle(40, 8'h01);
         end
         errs = 3'b000;
         wait_lock();
      end
      chk({4'h0, filter_setting[0]}, 8'h03);
      xfer(1'b1, ADDR_EQ_LIMIT, 8'hFF);
      errs = 3'b001;
      for (k = 0; k < 2; k++)
      begin
         xfer(1'b1, ADDR_EQ_CTL, k == 0 ? 8'h14 : 8'h10);
         lock0 = 1'b0;
         settle(20, 8'h01);
         lock0 = 1'b1;
         settle(40, k == 0 ? 8'h01 : 8'h00);
      end
      // filter as inner loop, then as outer loop, with a narrow ceiling
      sample_filter_ceiling = 4'h4;
      xfer(1'b1, ADDR_EQ_CTL, 8'h13);
      eq_old = eq_setting[0];
      lock0 = 1'b0;
      step_to(eq_old, 4'h4);
      step_to(eq_old + 4'h1, 4'h3);
      xfer(1'b1, ADDR_EQ_CTL, 8'h11);
      step_to(eq_old + 4'h2, eq_old == 4'hE ? 4'h4 : 4'h3);
      lock0 = 1'b1;
      sample_filter_floor = 4'hF;
      repeat (2) @(negedge clk);
      chk({4'h0, filter_setting[0]}, {4'h0, SF_LIMIT});
      $display("equalizer test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
